// *** logic/timer8_pkg.sv ***
// Constants, types and register map of the 8-bit timer waveform generator
package timer8_pkg;

  localparam int ADDR_W = 5;

  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_COUNT = 5'h04;
  localparam logic [4:0] OFF_COMPARE = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_PIN = 5'h10;

  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_COM_LSB = 4;
  localparam int CTRL_FORCE_BIT = 7;
  localparam int CTRL_CS_LSB = 8;
  localparam int STATUS_OVF_BIT = 0;
  localparam int STATUS_CMP_BIT = 1;
  localparam int STATUS_OUT_BIT = 2;
  localparam int PIN_DIR_BIT = 0;
  localparam int PIN_PORT_BIT = 1;

  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  localparam logic OUT_STATE_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int PRESC_W = 10;
  localparam int PRESC_DIV_1 = 1;
  localparam int PRESC_DIV_8 = 8;
  localparam int PRESC_DIV_64 = 64;
  localparam int PRESC_DIV_256 = 256;
  localparam int PRESC_DIV_1024 = 1024;

  typedef enum logic [1:0] {
    WAVE_NORMAL,
    WAVE_PHASE_PWM,
    WAVE_CLEAR_ON_MATCH,
    WAVE_FAST_PWM
  } waveform_mode_t;

  typedef enum logic [1:0] {
    COM_OFF,
    COM_TOGGLE,
    COM_CLEAR,
    COM_SET
  } compare_output_mode_t;

  typedef struct packed {
    logic [2:0] clock_select;
    compare_output_mode_t compare_output_mode;
    waveform_mode_t waveform_mode;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{clock_select: 3'h0, compare_output_mode: COM_OFF,
                                 waveform_mode: WAVE_NORMAL};

endpackage : timer8_pkg

// *** logic/timer8_waveform_generator.sv ***
// 8-bit timer counter, compare output unit and AXI4-Lite register slave
`timescale 1ns/1ps
module timer8_waveform_generator (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [timer8_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [timer8_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_overflow_ack,
  input wire logic i_compare_match_ack,
  output logic o_overflow_flag,
  output logic o_compare_match_flag,
  output logic o_compare_output_state,
  output logic o_pin_out,
  output logic o_pin_oe
);
  import timer8_pkg::*;

  // Bus state
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // Timer state
  ctrl_t ctrl_q, ctrl_d;
  logic [PRESC_W-1:0] presc_q, presc_d;
  logic [7:0] count_q, count_d;
  logic [7:0] cmp_buf_q, cmp_buf_d;
  logic [7:0] cmp_act_q, cmp_act_d;
  logic count_up_q, count_up_d;
  logic block_q, block_d;
  logic ovf_q, ovf_d;
  logic cmp_flag_q, cmp_flag_d;
  logic out_q, out_d;
  logic dir_q, dir_d;
  logic port_q, port_d;
  logic pin_out_q, pin_out_d;
  logic pin_oe_q, pin_oe_d;

  logic do_write;
  logic mapped_w;
  logic wr_ctrl, wr_count, wr_cmp, wr_status, wr_pin;
  logic force_cmp;
  logic tick;
  logic cmp_equal;
  logic match;
  logic at_bottom;
  logic ovf_set;
  logic is_pwm;
  compare_output_mode_t force_mode;

  function automatic logic [PRESC_W-1:0] presc_limit(input logic [2:0] cs);
    logic [PRESC_W-1:0] lim;
    lim = '0;
    case (cs)
      3'h1: lim = PRESC_W'(PRESC_DIV_1 - 1);
      3'h2: lim = PRESC_W'(PRESC_DIV_8 - 1);
      3'h3: lim = PRESC_W'(PRESC_DIV_64 - 1);
      3'h4: lim = PRESC_W'(PRESC_DIV_256 - 1);
      3'h5: lim = PRESC_W'(PRESC_DIV_1024 - 1);
      default: lim = '0;
    endcase
    return lim;
  endfunction : presc_limit

  // Set, clear or toggle as the output mode asks; mode zero holds
  function automatic logic non_pwm_action(input compare_output_mode_t com, input logic cur);
    logic nxt;
    nxt = cur;
    case (com)
      COM_TOGGLE: nxt = ~cur;
      COM_CLEAR: nxt = 1'b0;
      COM_SET: nxt = 1'b1;
      default: nxt = cur;
    endcase
    return nxt;
  endfunction : non_pwm_action

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_CTRL) || (a == OFF_COUNT) || (a == OFF_COMPARE) ||
           (a == OFF_STATUS) || (a == OFF_PIN);
  endfunction : is_mapped

  // Handshakes: one write and one read in flight at a time
  assign o_s_axi_awready = !aw_held_q && !bvalid_q;
  assign o_s_axi_wready = !w_held_q && !bvalid_q;
  assign o_s_axi_arready = !rvalid_q;
  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;
  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;
  assign o_overflow_flag = ovf_q;
  assign o_compare_match_flag = cmp_flag_q;
  assign o_compare_output_state = out_q;
  assign o_pin_out = pin_out_q;
  assign o_pin_oe = pin_oe_q;

  // Register slave
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = i_s_axi_wdata;
      wstrb_d = i_s_axi_wstrb;
    end
    do_write = aw_held_q && w_held_q && !bvalid_q;
    mapped_w = is_mapped(awaddr_q);
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped_w ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && i_s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = is_mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_d = '0;
      case (i_s_axi_araddr)
        OFF_CTRL: begin
          // Force strobe always reads as zero
          rdata_d[CTRL_WAVE_LSB +: 2] = ctrl_q.waveform_mode;
          rdata_d[CTRL_COM_LSB +: 2] = ctrl_q.compare_output_mode;
          rdata_d[CTRL_CS_LSB +: 3] = ctrl_q.clock_select;
        end
        OFF_COUNT: rdata_d[7:0] = count_q;
        OFF_COMPARE: rdata_d[7:0] = cmp_buf_q;
        OFF_STATUS: begin
          rdata_d[STATUS_OVF_BIT] = ovf_q;
          rdata_d[STATUS_CMP_BIT] = cmp_flag_q;
          rdata_d[STATUS_OUT_BIT] = out_q;
        end
        OFF_PIN: begin
          rdata_d[PIN_DIR_BIT] = dir_q;
          rdata_d[PIN_PORT_BIT] = port_q;
        end
        default: rdata_d = '0;
      endcase
    end else if (rvalid_q && i_s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Timer, compare unit and pin override
  always_comb begin
    ctrl_d = ctrl_q;
    presc_d = presc_q;
    count_d = count_q;
    cmp_buf_d = cmp_buf_q;
    cmp_act_d = cmp_act_q;
    count_up_d = count_up_q;
    block_d = block_q;
    ovf_d = ovf_q;
    cmp_flag_d = cmp_flag_q;
    out_d = out_q;
    dir_d = dir_q;
    port_d = port_q;
    ovf_set = 1'b0;
    at_bottom = 1'b0;
    wr_ctrl = do_write && (awaddr_q == OFF_CTRL);
    wr_count = do_write && (awaddr_q == OFF_COUNT) && wstrb_q[0];
    wr_cmp = do_write && (awaddr_q == OFF_COMPARE) && wstrb_q[0];
    wr_status = do_write && (awaddr_q == OFF_STATUS) && wstrb_q[0];
    wr_pin = do_write && (awaddr_q == OFF_PIN) && wstrb_q[0];
    if (wr_ctrl && wstrb_q[0]) begin
      ctrl_d.waveform_mode = waveform_mode_t'(wdata_q[CTRL_WAVE_LSB +: 2]);
      ctrl_d.compare_output_mode = compare_output_mode_t'(wdata_q[CTRL_COM_LSB +: 2]);
    end
    if (wr_ctrl && wstrb_q[1]) begin
      ctrl_d.clock_select = wdata_q[CTRL_CS_LSB +: 3];
    end
    // A force acts with the output mode written in the same access
    force_mode = ctrl_d.compare_output_mode;
    force_cmp = wr_ctrl && wstrb_q[0] && wdata_q[CTRL_FORCE_BIT];
    if (wr_pin) begin
      dir_d = wdata_q[PIN_DIR_BIT];
      port_d = wdata_q[PIN_PORT_BIT];
    end
    // Prescaled timer tick; clock select zero stops the counter
    tick = (ctrl_q.clock_select != 3'h0) && (presc_q == presc_limit(ctrl_q.clock_select));
    if (ctrl_q.clock_select == 3'h0 || tick) begin
      presc_d = '0;
    end else begin
      presc_d = presc_q + PRESC_W'(1);
    end
    is_pwm = (ctrl_q.waveform_mode == WAVE_FAST_PWM) ||
             (ctrl_q.waveform_mode == WAVE_PHASE_PWM);
    cmp_equal = (count_q == cmp_act_q);
    match = tick && cmp_equal && !block_q;
    // Count sequence depends on the waveform mode, and in clear-on-match mode also on the compare value
    if (tick) begin
      case (ctrl_q.waveform_mode)
        WAVE_NORMAL: begin
          count_d = count_q + 8'h01;
          ovf_set = (count_q == COUNT_MAX);
        end
        WAVE_CLEAR_ON_MATCH: begin
          // Equality with the live compare value is the top; a top written
          // below the count is missed until the counter wraps
          if (cmp_equal) begin
            count_d = COUNT_BOTTOM;
          end else begin
            count_d = count_q + 8'h01;
          end
          ovf_set = (count_q == COUNT_MAX);
        end
        WAVE_FAST_PWM: begin
          if (count_q == COUNT_MAX) begin
            count_d = COUNT_BOTTOM;
            at_bottom = 1'b1;
            ovf_set = 1'b1;
          end else begin
            count_d = count_q + 8'h01;
          end
        end
        WAVE_PHASE_PWM: begin
          if (count_up_q) begin
            if (count_q == COUNT_MAX) begin
              count_up_d = 1'b0;
              count_d = count_q - 8'h01;
            end else begin
              count_d = count_q + 8'h01;
            end
          end else if (count_q == COUNT_BOTTOM) begin
            count_up_d = 1'b1;
            count_d = count_q + 8'h01;
            ovf_set = 1'b1;
          end else begin
            count_d = count_q - 8'h01;
          end
        end
        default: count_d = count_q;
      endcase
    end
    // Software count write beats the count step in any mode; the direction and the overflow flag still update
    if (wr_count) begin
      count_d = wdata_q[7:0];
      block_d = 1'b1;
    end else if (tick) begin
      block_d = 1'b0;
    end
    // Compare value: direct outside PWM, taken at max in PWM modes
    if (wr_cmp) begin
      cmp_buf_d = wdata_q[7:0];
    end
    if (!is_pwm) begin
      cmp_act_d = cmp_buf_d;
    end else if (tick && count_q == COUNT_MAX) begin
      cmp_act_d = cmp_buf_q;
    end
    // Internal output state; the registered output mode governs a match, not one written in that cycle
    case (ctrl_q.waveform_mode)
      WAVE_FAST_PWM: begin
        if (match) begin
          case (ctrl_q.compare_output_mode)
            COM_TOGGLE: out_d = ~out_q;
            COM_CLEAR: out_d = 1'b0;
            COM_SET: out_d = 1'b1;
            default: out_d = out_q;
          endcase
        end
        // Bottom wins over a match at max so compare max gives a steady level in clear and set modes
        if (at_bottom) begin
          case (ctrl_q.compare_output_mode)
            COM_CLEAR: out_d = 1'b1;
            COM_SET: out_d = 1'b0;
            default: out_d = out_d;
          endcase
        end
      end
      WAVE_PHASE_PWM: begin
        if (match) begin
          case (ctrl_q.compare_output_mode)
            COM_CLEAR: out_d = !count_up_q;
            COM_SET: out_d = count_up_q;
            default: out_d = out_q;
          endcase
        end
      end
      default: begin
        if (match) begin
          out_d = non_pwm_action(ctrl_q.compare_output_mode, out_q);
        end
        // Force changes the state only: no flag, no counter clear
        if (force_cmp) begin
          out_d = non_pwm_action(force_mode, out_d);
        end
      end
    endcase
    // Flags: a set in the same cycle as a clear wins
    if ((wr_status && wdata_q[STATUS_OVF_BIT]) || i_overflow_ack) begin
      ovf_d = 1'b0;
    end
    if (ovf_set) begin
      ovf_d = 1'b1;
    end
    if ((wr_status && wdata_q[STATUS_CMP_BIT]) || i_compare_match_ack) begin
      cmp_flag_d = 1'b0;
    end
    if (match) begin
      cmp_flag_d = 1'b1;
    end
    // Pin: override by output mode alone, direction from the direction bit
    pin_out_d = (ctrl_d.compare_output_mode != COM_OFF) ? out_d : port_d;
    pin_oe_d = dir_d;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RST;
      presc_q <= '0;
      count_q <= COUNT_RST;
      cmp_buf_q <= COMPARE_RST;
      cmp_act_q <= COMPARE_RST;
      count_up_q <= 1'b1;
      block_q <= 1'b0;
      ovf_q <= 1'b0;
      cmp_flag_q <= 1'b0;
      out_q <= OUT_STATE_RST;
      dir_q <= 1'b0;
      port_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      presc_q <= presc_d;
      count_q <= count_d;
      cmp_buf_q <= cmp_buf_d;
      cmp_act_q <= cmp_act_d;
      count_up_q <= count_up_d;
      block_q <= block_d;
      ovf_q <= ovf_d;
      cmp_flag_q <= cmp_flag_d;
      out_q <= out_d;
      dir_q <= dir_d;
      port_q <= port_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

endmodule : timer8_waveform_generator

// *** test/pin_load.sv ***
// Port pin with pull-up and external load
`timescale 1ns/1ps
module pin_load (
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  output logic o_level
);
  // Undriven pin floats to the pull-up, never to the last driven value
  assign o_level = i_pin_oe ? i_pin_out : 1'b1;
endmodule : pin_load

// *** test/tb_timer8_waveform_generator.sv ***
// Self-checking bench for the timer waveform generator
`timescale 1ns/1ps
module tb_timer8_waveform_generator;
  import timer8_pkg::*;
  logic i_clk, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid;
  logic i_s_axi_rready, i_overflow_ack, i_compare_match_ack, o_s_axi_awready, o_s_axi_wready;
  logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_overflow_flag, o_compare_match_flag;
  logic o_compare_output_state, o_pin_out, o_pin_oe, pin_level, s;
  logic [4:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rdat;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
  logic [7:0] cv;
  int miscompares = 0, cmp_count = 0, cyc = 0, n;
  localparam logic [1:0] FCOM [6] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3, 2'h0};
  localparam logic FEXP [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  timer8_waveform_generator timer8_waveform_generator_i (.i_clk, .i_rst_n, .i_s_axi_awaddr,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
    .i_s_axi_rready, .i_overflow_ack, .i_compare_match_ack, .o_overflow_flag,
    .o_compare_match_flag, .o_compare_output_state, .o_pin_out, .o_pin_oe);
  pin_load pin_load_i (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .o_level(pin_level));
  // Fast PWM high ticks per 256, normal then inverted; phase PWM high ticks per 510
  function automatic logic [31:0] pwm_high(input logic [7:0] c, input int m);
    return (m == 2) ? 32'(c) * 32'h0000_0002 :
           (m == 1) ? 32'(8'hFF - c) : 32'(c) + 32'h0000_0001;
  endfunction : pwm_high
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Each channel drops at the rising edge that takes it; the answer is taken at that edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    do begin
      @(posedge i_clk);
      if (aw && o_s_axi_awready) begin
        aw = 1'b0;
        i_s_axi_awvalid <= 1'b0;
      end
      if (w && o_s_axi_wready) begin
        w = 1'b0;
        i_s_axi_wvalid <= 1'b0;
      end
    end while (o_s_axi_bvalid !== 1'b1);
    resp = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    logic ar;
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    ar = 1'b1;
    do begin
      @(posedge i_clk);
      if (ar && o_s_axi_arready) begin
        ar = 1'b0;
        i_s_axi_arvalid <= 1'b0;
      end
    end while (o_s_axi_rvalid !== 1'b1);
    rdat = o_s_axi_rdata;
    resp = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle
  task automatic tog(output int k);
    s = o_compare_output_state;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_compare_output_state === s && k < 2000);
  endtask : tog
  task automatic ovf_wait();
    n = 0;
    while (o_overflow_flag !== 1'b1 && n < 400) begin
      @(negedge i_clk);
      n++;
    end
  endtask : ovf_wait
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Ceiling sits well above the few thousand cycles the sequence needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    {i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = '0;
    {i_s_axi_rready, i_overflow_ack, i_compare_match_ack} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
    i_s_axi_wstrb = 4'hF;
    void'($urandom(32'ha099_592d));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk("state", o_compare_output_state, OUT_STATE_RST);
    rd(OFF_COUNT);
    chk("count", rdat, 32'h0000_0000);
    rd(5'h14);
    chk("rresp", resp, RESP_SLVERR);
    chk("rdata", rdat, 32'h0000_0000);
    wr(5'h14, 32'hFFFF_FFFF);
    chk("bresp", resp, RESP_SLVERR);
    foreach (FCOM[k]) begin
      wr(OFF_CTRL, {24'h00_0000, 2'h2, FCOM[k], 4'h0});
      chk("forced", o_compare_output_state, FEXP[k]);
    end
    chk("flags", {o_overflow_flag, o_compare_match_flag}, 32'h0000_0000);
    rd(OFF_COUNT);
    chk("count", rdat, 32'h0000_0000);
    wr(OFF_PIN, 32'h0000_0001);
    chk("bresp", resp, RESP_OKAY);
    settle();
    chk("pin", pin_level, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0030);
    settle();
    chk("pin", pin_level, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0032);
    settle();
    chk("pin", o_pin_out, 32'h0000_0001);
    wr(OFF_PIN, 32'h0000_0000);
    settle();
    chk("oe", {o_pin_oe, pin_level}, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_COUNT, 32'h0000_00F0);
    wr(OFF_CTRL, 32'h0000_0100);
    ovf_wait();
    chk("ovf wait", 32'(n inside {[14:18]}), 32'h0000_0001);
    @(posedge i_clk);
    i_overflow_ack <= 1'b1;
    @(posedge i_clk);
    i_overflow_ack <= 1'b0;
    @(negedge i_clk);
    chk("ovf ack", o_overflow_flag, 32'h0000_0000);
    wr(OFF_COUNT, 32'h0000_00FD);
    ovf_wait();
    chk("ovf rewrite", 32'(n inside {[1:6]}), 32'h0000_0001);
    wr(OFF_STATUS, 32'h0000_0003);
    @(negedge i_clk);
    chk("ovf w1c", o_overflow_flag, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_COMPARE, 32'h0000_0005);
    wr(OFF_COUNT, 32'h0000_0005);
    wr(OFF_CTRL, 32'h0000_0112);
    s = o_compare_output_state;
    settle();
    chk("blocked", {o_compare_output_state, o_compare_match_flag}, {s, 1'b0});
    cv = 8'($urandom_range(3, 40));
    wr(OFF_COMPARE, {24'h00_0000, cv});
    tog(n);
    tog(n);
    chk("half period", n, 32'(cv) + 32'h0000_0001);
    chk("cmp flag", o_compare_match_flag, 32'h0000_0001);
    @(posedge i_clk);
    i_compare_match_ack <= 1'b1;
    @(posedge i_clk);
    i_compare_match_ack <= 1'b0;
    @(negedge i_clk);
    chk("cmp ack", o_compare_match_flag, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0012);
    wr(OFF_STATUS, 32'h0000_0003);
    wr(OFF_COUNT, 32'h0000_0080);
    wr(OFF_COMPARE, 32'h0000_0010);
    wr(OFF_CTRL, 32'h0000_0112);
    tog(n);
    chk("late match", 32'(n inside {[141:148]}), 32'h0000_0001);
    chk("ctc ovf", o_overflow_flag, 32'h0000_0001);
    cv = 8'($urandom_range(16, 224));
    wr(OFF_COMPARE, {24'h00_0000, cv});
    // Fast PWM normal, fast PWM inverted, then phase PWM normal
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CTRL, (m == 2) ? 32'h0000_0121 : (m == 1) ? 32'h0000_0133 : 32'h0000_0123);
      repeat (600) @(negedge i_clk);
      n = 0;
      repeat ((m == 2) ? 510 : 256) begin
        @(negedge i_clk);
        n += int'(o_compare_output_state);
      end
      chk("pwm high", n, pwm_high(cv, m));
    end
    finish_test();
  end
endmodule : tb_timer8_waveform_generator

// *** test/timer8_properties.sv ***
// Port-level checker for the timer waveform generator
`timescale 1ns/1ps
module timer8_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_overflow_ack,
  input wire logic i_compare_match_ack,
  input wire logic o_overflow_flag,
  input wire logic o_compare_match_flag,
  input wire logic o_compare_output_state,
  input wire logic o_pin_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Reset itself is watched, so this one is never disabled
  reset_clear_a: assert property (disable iff (1'b0) !i_rst_n |=>
    !o_compare_output_state && !o_pin_oe && !o_overflow_flag) else $error("reset state");
  ovf_sticky_a: assert property ($fell(o_overflow_flag) |->
    $past(i_overflow_ack) || $rose(o_s_axi_bvalid)) else $error("overflow flag lost");
  cmp_sticky_a: assert property ($fell(o_compare_match_flag) |->
    $past(i_compare_match_ack) || $rose(o_s_axi_bvalid)) else $error("match flag lost");
  resp_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken during response");
  bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped");
  arready_rule_a: assert property (o_s_axi_arready == !o_s_axi_rvalid)
    else $error("arready wrong");
  read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
    o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid) else $error("write not answered");
endmodule : timer8_properties
bind timer8_waveform_generator timer8_properties timer8_properties_i (.i_clk, .i_rst_n,
  .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
  .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
  .o_s_axi_rvalid, .i_s_axi_rready, .i_overflow_ack, .i_compare_match_ack,
  .o_overflow_flag, .o_compare_match_flag, .o_compare_output_state, .o_pin_oe);
